// ### src/spcc_pkg.sv
// Package: register map, field layouts, reset values and types of the synth config control
package spcc_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OSC_CTRL_OFF  = 8'h00;
  localparam logic [7:0] FREQ_LO_OFF   = 8'h04;
  localparam logic [7:0] FREQ_HI_OFF   = 8'h08;
  localparam logic [7:0] LOOP_EN_OFF   = 8'h0C;
  localparam logic [7:0] PLL_CTL3_OFF  = 8'h10;
  localparam logic [7:0] IN_CTL_OFF    = 8'h14;
  localparam logic [7:0] FB_INT_LO_OFF = 8'h18;
  localparam logic [7:0] FB_INT_HI_OFF = 8'h1C;
  localparam logic [7:0] FB_REM_OFF    = 8'h20;
  localparam logic [7:0] FB_DEN_OFF    = 8'h24;
  localparam logic [7:0] FB_BP_OFF     = 8'h28;
  localparam logic [7:0] STATUS_OFF    = 8'h2C;
  localparam logic [7:0] PLL_CTL4_OFF  = 8'h30;
  localparam logic [7:0] OUT_CTL_OFF   = 8'h34;
  localparam logic [7:0] OUT_EN_OFF    = 8'h38;
  localparam logic [7:0] SS_RATE_OFF   = 8'h3C;

  // ----------------------------------------------------------------
  // Codes and field positions
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_NCO      = 4'h1;
  localparam logic [3:0] MODE_SS       = 4'h2;
  localparam logic [2:0] SEL_OSC_BLOCK = 3'h6;
  localparam int         FB_FRAC_MAX   = 33;
  localparam int         FB_INT_BITS   = 9;
  localparam int         FB_INT_W      = FB_INT_BITS + FB_FRAC_MAX;
  localparam int         OUT_FIELD_W   = 8;
  localparam int         IN_FIELD_W    = 4;
  localparam int         PHASE_STEPS   = 8;
  localparam int         PIN_SYNC_W    = 3;

  // Spread settings: deviation in units of 0.01 percent, rates in kHz
  localparam logic [5:0]  SS_DEV_MAX   = 6'h32;
  localparam logic [7:0]  SS_RATE_MIN  = 8'h19;
  localparam logic [7:0]  SS_RATE_MAX  = 8'h37;
  localparam int          CLK_KHZ      = 40000;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] OSC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SS_RATE_RST  = 32'h0032_0019;
  localparam logic [31:0] FB_BP_RST    = 32'h0000_0009;
  localparam logic [31:0] FB_DEN_RST   = 32'h0000_0001;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPCC_FMT_OFF      = 3'h0,
    SPCC_FMT_CML800   = 3'h1,
    SPCC_FMT_CML400   = 3'h2,
    SPCC_FMT_HSTL     = 3'h3,
    SPCC_FMT_CMOS_NOFF = 3'h4,
    SPCC_FMT_CMOS_NIN = 3'h5,
    SPCC_FMT_CMOS_NINV = 3'h6
  } spcc_format_type;

  typedef enum logic [1:0] {
    SPCC_SS_UP   = 2'b01,
    SPCC_SS_DOWN = 2'b10
  } spcc_ss_state_type;

  typedef struct packed {
    logic            enable;
    logic            invert;
    logic [1:0]      drive;
    logic            cml_half_swing;
    logic            neg_enable;
    logic            neg_invert;
    logic            hi_z;
  } spcc_out_ctl_type;

  typedef struct packed {
    logic [2:0]      ref_select;
    logic [1:0]      divide_log2;
    logic            in_invert;
    logic            loop_enable;
    logic            osc_enable;
  } spcc_loop_ctl_type;

  typedef struct packed {
    logic            step;
    logic            advance;
  } spcc_phase_step_type;

endpackage

// ### src/spcc_top.sv
// Module: register file and control logic of the fractional synthesizer configuration
//
// Operation
// - Mode code 0010 with the oscillator enabled selects spread-spectrum modulation
// - Spread modulates around 40-bit frequency word
// - Triangle center spread, deviation capped at SS_DEV_MAX; rate not capped, only a zero rate uses SS_RATE_MIN
// - Reference from inputs, crystal, or oscillator
// - Switch disabled: primary select only
// - Switch enabled: pin picks primary or alternate
// - Input divider divides by 1,2,4,8
// - Per-input polarity bit inverts the input
// - Loop active only while enable bit set
// - Feedback value from integer, remainder, denominator, point
// - Live lock and unlock status bits
// - Each step moves phase one eighth cycle
// - Step sources: command bit or four pins
// - Step on both edges, both dividers
// - Output works only with format and enable
// - Format selects off, CML, HSTL or CMOS
// - Polarity bit inverts output driver clock
// - Four drive strengths per CMOS/HSTL driver
// - Mode code 0001 selects plain oscillator
// - Oscillator block is reference for select 11x
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module spcc_top #(
  parameter int N_IN  = 3,
  parameter int N_OUT = 3,
  parameter int N_PIN = 4
) (
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  input  wire logic                          clk_en,
  input  wire logic [31:0]                   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [31:0]                   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic [N_PIN-1:0]              gp_pin,
  input  wire logic                          loop_locked,
  output logic [3:0]                         osc_mode,
  output logic                               osc_enable_out,
  output logic                               ss_active,
  output logic signed [39:0]                 ss_offset,
  output logic [39:0]                        osc_frequency_word,
  output logic [2:0]                         ref_select,
  output logic [N_IN-1:0][1:0]               in_divide_log2,
  output logic [N_IN-1:0]                    in_invert,
  output logic                               loop_enable_out,
  output logic [spcc_pkg::FB_INT_W-1:0]      feedback_integer_part,
  output logic [31:0]                        feedback_remainder,
  output logic [31:0]                        feedback_denominator,
  output logic [5:0]                         feedback_point_position,
  output spcc_pkg::spcc_phase_step_type      phase_step,
  output spcc_pkg::spcc_out_ctl_type [N_OUT-1:0] out_ctl
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] osc_ctl_q, freq_lo_q, freq_hi_q, loop_en_q, ctl3_q, in_ctl_q;
  logic [31:0] fb_lo_q, fb_hi_q, fb_rem_q, fb_den_q, fb_bp_q, ctl4_q;
  logic [31:0] out_ctl_q, out_en_q, ss_rate_q;
  logic [31:0] aw_addr_q, w_data_q;
  logic [3:0]  w_strb_q;
  logic        aw_full_q, w_full_q;
  logic [2:0][N_PIN-1:0] pin_sync_q;
  logic [2:0]  lock_sync_q;
  logic        lock_level_q;
  logic        dec_level_q, inc_level_q;
  logic        alt_active_q;
  logic        do_write;

  assign do_write = aw_full_q && w_full_q && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Write channel: address and data taken in either order
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q    <= 1'b0;
      w_full_q     <= 1'b0;
      aw_addr_q    <= 32'h0000_0000;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_q[7:0] > spcc_pkg::SS_RATE_OFF ||
                         aw_addr_q[31:8] != 24'h00_0000 ||
                         aw_addr_q[7:0] == spcc_pkg::STATUS_OFF) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_full_q;
  assign s_axi_wready  = !w_full_q;

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_ctl_q <= spcc_pkg::OSC_CTRL_RST;
      freq_lo_q <= 32'h0000_0000;
      freq_hi_q <= 32'h0000_0000;
      loop_en_q <= 32'h0000_0000;
      ctl3_q    <= 32'h0000_0000;
      in_ctl_q  <= 32'h0000_0000;
      fb_lo_q   <= 32'h0000_0000;
      fb_hi_q   <= 32'h0000_0000;
      fb_rem_q  <= 32'h0000_0000;
      fb_den_q  <= spcc_pkg::FB_DEN_RST;
      fb_bp_q   <= spcc_pkg::FB_BP_RST;
      ctl4_q    <= 32'h0000_0000;
      out_ctl_q <= 32'h0000_0000;
      out_en_q  <= 32'h0000_0000;
      ss_rate_q <= spcc_pkg::SS_RATE_RST;
    end else if (clk_en && do_write && aw_addr_q[31:8] == 24'h00_0000) begin
      unique case (aw_addr_q[7:0])
        spcc_pkg::OSC_CTRL_OFF:  osc_ctl_q <= merge(osc_ctl_q, w_data_q, w_strb_q);
        spcc_pkg::FREQ_LO_OFF:   freq_lo_q <= merge(freq_lo_q, w_data_q, w_strb_q);
        spcc_pkg::FREQ_HI_OFF:   freq_hi_q <= merge(freq_hi_q, w_data_q, w_strb_q);
        spcc_pkg::LOOP_EN_OFF:   loop_en_q <= merge(loop_en_q, w_data_q, w_strb_q);
        spcc_pkg::PLL_CTL3_OFF:  ctl3_q    <= merge(ctl3_q, w_data_q, w_strb_q);
        spcc_pkg::IN_CTL_OFF:    in_ctl_q  <= merge(in_ctl_q, w_data_q, w_strb_q);
        spcc_pkg::FB_INT_LO_OFF: fb_lo_q   <= merge(fb_lo_q, w_data_q, w_strb_q);
        spcc_pkg::FB_INT_HI_OFF: fb_hi_q   <= merge(fb_hi_q, w_data_q, w_strb_q);
        spcc_pkg::FB_REM_OFF:    fb_rem_q  <= merge(fb_rem_q, w_data_q, w_strb_q);
        spcc_pkg::FB_DEN_OFF:    fb_den_q  <= merge(fb_den_q, w_data_q, w_strb_q);
        spcc_pkg::FB_BP_OFF:     fb_bp_q   <= merge(fb_bp_q, w_data_q, w_strb_q);
        spcc_pkg::PLL_CTL4_OFF:  ctl4_q    <= merge(ctl4_q, w_data_q, w_strb_q);
        spcc_pkg::OUT_CTL_OFF:   out_ctl_q <= merge(out_ctl_q, w_data_q, w_strb_q);
        spcc_pkg::OUT_EN_OFF:    out_en_q  <= merge(out_en_q, w_data_q, w_strb_q);
        spcc_pkg::SS_RATE_OFF:   ss_rate_q <= merge(ss_rate_q, w_data_q, w_strb_q);
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic        rd_ok;
  always_comb begin
    rd_ok  = (s_axi_araddr[31:8] == 24'h00_0000);
    rd_mux = 32'h0000_0000;
    unique case (s_axi_araddr[7:0])
      spcc_pkg::OSC_CTRL_OFF:  rd_mux = osc_ctl_q;
      spcc_pkg::FREQ_LO_OFF:   rd_mux = freq_lo_q;
      spcc_pkg::FREQ_HI_OFF:   rd_mux = {24'h00_0000, freq_hi_q[7:0]};
      spcc_pkg::LOOP_EN_OFF:   rd_mux = loop_en_q;
      spcc_pkg::PLL_CTL3_OFF:  rd_mux = ctl3_q;
      spcc_pkg::IN_CTL_OFF:    rd_mux = in_ctl_q;
      spcc_pkg::FB_INT_LO_OFF: rd_mux = fb_lo_q;
      spcc_pkg::FB_INT_HI_OFF: rd_mux = {22'h00_0000, fb_hi_q[9:0]};
      spcc_pkg::FB_REM_OFF:    rd_mux = fb_rem_q;
      spcc_pkg::FB_DEN_OFF:    rd_mux = fb_den_q;
      spcc_pkg::FB_BP_OFF:     rd_mux = {26'h000_0000, fb_bp_q[5:0]};
      spcc_pkg::STATUS_OFF:    rd_mux = {29'h0000_0000, alt_active_q,
                                         !lock_level_q, lock_level_q};
      spcc_pkg::PLL_CTL4_OFF:  rd_mux = ctl4_q;
      spcc_pkg::OUT_CTL_OFF:   rd_mux = out_ctl_q;
      spcc_pkg::OUT_EN_OFF:    rd_mux = out_en_q;
      spcc_pkg::SS_RATE_OFF:   rd_mux = ss_rate_q;
      default:                 rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_ok ? rd_mux : 32'h0000_0000;
        s_axi_rresp  <= rd_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  // ----------------------------------------------------------------
  // Pin and lock synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_sync_q  <= '0;
      lock_sync_q <= 3'b000;
    end else if (clk_en) begin
      pin_sync_q  <= {pin_sync_q[1:0], gp_pin};
      lock_sync_q <= {lock_sync_q[1:0], loop_locked};
    end
  end

  // Lock input is asynchronous too: same agreement filter as the pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_level_q <= 1'b0;
    end else if (clk_en && lock_sync_q[1] == lock_sync_q[2]) begin
      lock_level_q <= lock_sync_q[2];
    end
  end

  // Level counts only once stages two and three agree
  logic [N_PIN-1:0] pin_level_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_level_q <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < N_PIN; i++) begin
        if (pin_sync_q[1][i] == pin_sync_q[2][i]) begin
          pin_level_q[i] <= pin_sync_q[2][i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Reference selection
  // ----------------------------------------------------------------
  logic [2:0] sel_d;
  always_comb begin
    sel_d = ctl3_q[2:0];
    if (ctl3_q[8] && pin_level_q[ctl3_q[13:12]]) begin
      sel_d = ctl3_q[6:4];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_select   <= 3'h0;
      alt_active_q <= 1'b0;
    end else if (clk_en) begin
      ref_select   <= sel_d;
      alt_active_q <= ctl3_q[8] && pin_level_q[ctl3_q[13:12]];
    end
  end

  // ----------------------------------------------------------------
  // Loop, inputs, feedback and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      loop_enable_out         <= 1'b0;
      osc_enable_out          <= 1'b0;
      osc_mode                <= 4'h0;
      osc_frequency_word      <= 40'h00_0000_0000;
      feedback_integer_part   <= '0;
      feedback_remainder      <= 32'h0000_0000;
      feedback_denominator    <= spcc_pkg::FB_DEN_RST;
      feedback_point_position <= spcc_pkg::FB_BP_RST[5:0];
      in_divide_log2          <= '0;
      in_invert               <= '0;
      out_ctl                 <= '0;
    end else if (clk_en) begin
      loop_enable_out         <= loop_en_q[0];
      osc_enable_out          <= loop_en_q[1];
      osc_mode                <= osc_ctl_q[3:0];
      osc_frequency_word      <= {freq_hi_q[7:0], freq_lo_q};
      feedback_integer_part   <= {fb_hi_q[9:0], fb_lo_q};
      feedback_remainder      <= fb_rem_q;
      feedback_denominator    <= fb_den_q;
      feedback_point_position <= (fb_bp_q[5:0] > 6'd33) ? 6'd33 : fb_bp_q[5:0];
      for (int i = 0; i < N_IN; i++) begin
        in_divide_log2[i] <= in_ctl_q[spcc_pkg::IN_FIELD_W*i +: 2];
        in_invert[i]      <= in_ctl_q[spcc_pkg::IN_FIELD_W*i + 2];
      end
      for (int o = 0; o < N_OUT; o++) begin
        automatic logic [2:0] fmt = out_ctl_q[spcc_pkg::OUT_FIELD_W*o +: 3];
        out_ctl[o].enable         <= (fmt != 3'h0) && out_en_q[o];
        out_ctl[o].hi_z           <= (fmt == 3'h0);
        out_ctl[o].cml_half_swing <= (fmt == spcc_pkg::SPCC_FMT_CML400);
        out_ctl[o].neg_enable     <= (fmt == spcc_pkg::SPCC_FMT_CMOS_NIN) ||
                                     (fmt == spcc_pkg::SPCC_FMT_CMOS_NINV) ||
                                     (fmt < spcc_pkg::SPCC_FMT_CMOS_NOFF && fmt != 3'h0);
        out_ctl[o].neg_invert     <= (fmt == spcc_pkg::SPCC_FMT_CMOS_NINV);
        out_ctl[o].invert         <= out_ctl_q[spcc_pkg::OUT_FIELD_W*o + 3];
        out_ctl[o].drive          <= out_ctl_q[spcc_pkg::OUT_FIELD_W*o + 4 +: 2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Phase steps on both edges of the chosen source
  // ----------------------------------------------------------------
  logic dec_src, inc_src;
  always_comb begin
    dec_src = (ctl4_q[2:0] == 3'h0) ? ctl4_q[8] : pin_level_q[ctl4_q[1:0] - 2'd1 + 2'd0];
    inc_src = (ctl4_q[6:4] == 3'h0) ? ctl4_q[9] : pin_level_q[ctl4_q[5:4] - 2'd1 + 2'd0];
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dec_level_q <= 1'b0;
      inc_level_q <= 1'b0;
      phase_step  <= '0;
    end else if (clk_en) begin
      dec_level_q        <= dec_src;
      inc_level_q        <= inc_src;
      phase_step.step    <= (dec_src != dec_level_q) ^ (inc_src != inc_level_q);
      phase_step.advance <= (inc_src != inc_level_q);
    end
  end

  // ----------------------------------------------------------------
  // Triangle spread generator
  // ----------------------------------------------------------------
  spcc_pkg::spcc_ss_state_type ss_dir_q;
  logic [23:0] ss_tick_q;
  logic [23:0] ss_half_period;
  logic [39:0] ss_step, ss_peak;
  assign ss_half_period = 24'(spcc_pkg::CLK_KHZ / (2 * int'(ss_rate_q[7:0] == 8'h0 ?
                            spcc_pkg::SS_RATE_MIN : ss_rate_q[7:0])));
  assign ss_peak = 40'((osc_frequency_word / 40'd10000) *
                   40'(ss_rate_q[21:16] > spcc_pkg::SS_DEV_MAX ?
                       spcc_pkg::SS_DEV_MAX : ss_rate_q[21:16]));
  assign ss_step = (ss_half_period == 24'h0) ? 40'h0 : 40'((2 * ss_peak) / 40'(ss_half_period));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ss_dir_q  <= spcc_pkg::SPCC_SS_UP;
      ss_tick_q <= 24'h00_0000;
      ss_offset <= 40'sh00_0000_0000;
      ss_active <= 1'b0;
    end else if (clk_en) begin
      ss_active <= (osc_mode == spcc_pkg::MODE_SS) && osc_enable_out;
      if (!ss_active) begin
        ss_tick_q <= 24'h00_0000;
        ss_dir_q  <= spcc_pkg::SPCC_SS_UP;
        ss_offset <= 40'sh00_0000_0000;
      end else begin
        ss_tick_q <= (ss_tick_q + 24'h1 >= ss_half_period) ? 24'h0 : ss_tick_q + 24'h1;
        unique case (ss_dir_q)
          spcc_pkg::SPCC_SS_UP: begin
            if ($signed(ss_offset) >= $signed(ss_peak)) ss_dir_q <= spcc_pkg::SPCC_SS_DOWN;
            else ss_offset <= ss_offset + $signed(ss_step);
          end
          spcc_pkg::SPCC_SS_DOWN: begin
            if ($signed(ss_offset) <= -$signed(ss_peak)) ss_dir_q <= spcc_pkg::SPCC_SS_UP;
            else ss_offset <= ss_offset - $signed(ss_step);
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence edge_seen_s;
    clk_en && (dec_src != dec_level_q);
  endsequence

  ss_mode_gate_a: assert property (
    clk_en && ss_active |-> $past(osc_mode) == spcc_pkg::MODE_SS)
    else $error("spread active outside spread mode");
  loop_enable_a: assert property (
    clk_en |=> loop_enable_out == $past(loop_en_q[0]))
    else $error("loop enable not following bit");
  out_gate_a: assert property (
    clk_en |=> out_ctl[0].enable == ($past(out_ctl_q[2:0]) != 3'h0 && $past(out_en_q[0])))
    else $error("output enable not gated by format");
  step_edge_a: assert property (
    (edge_seen_s and (inc_src == inc_level_q)) |=> phase_step.step)
    else $error("missed phase step");
  step_dir_a: assert property (
    phase_step.step && phase_step.advance |-> $past(inc_src != inc_level_q))
    else $error("advance without increment edge");
  switch_off_a: assert property (
    clk_en && !ctl3_q[8] |=> ref_select == $past(ctl3_q[2:0]))
    else $error("primary select not used");
  switch_alt_a: assert property (
    clk_en && ctl3_q[8] && pin_level_q[ctl3_q[13:12]] |=> ref_select == $past(ctl3_q[6:4]))
    else $error("alternate select not used");
  ss_bound_a: assert property (
    ss_active |-> $signed(ss_offset) <= $signed(ss_peak) + $signed(ss_step))
    else $error("spread exceeds deviation");

endmodule

// ### tb/test_synth_pll_config_control.sv
// Testbench: register-level tests of the synth config control block
`timescale 1ns/1ps
module test_synth_pll_config_control;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0000_0000, s_axi_wdata = 32'h0000_0000;
  logic [31:0] s_axi_araddr = 32'h0000_0000, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, loop_locked = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rrsp;
  logic [3:0]  gp_pin = 4'h0;
  logic [2:0]  ref_select, in_invert;
  logic        ss_active, loop_enable_out;
  logic [31:0] feedback_denominator, rdat;
  logic [39:0] osc_frequency_word;
  logic [2:0][1:0] in_divide_log2;
  spcc_pkg::spcc_phase_step_type phase_step;
  spcc_pkg::spcc_out_ctl_type [2:0] out_ctl;
  int          num_errors = 0, checks = 0, steps = 0, advs = 0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (phase_step.step === 1'b1) steps++;
    if (phase_step.step === 1'b1 && phase_step.advance === 1'b1) advs++;
  end
  spcc_top i_dut (.core_clk, .rst_n, .clk_en(1'b1), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .gp_pin,
    .loop_locked, .osc_mode(), .osc_enable_out(), .ss_active, .ss_offset(),
    .osc_frequency_word, .ref_select, .in_divide_log2, .in_invert, .loop_enable_out,
    .feedback_integer_part(), .feedback_remainder(), .feedback_denominator,
    .feedback_point_position(), .phase_step, .out_ctl);
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    b = 1'b0;
    s_axi_awaddr <= {24'h00_0000, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // Read right after the edge: slave updates land later in the step
    while (!b) begin
      @(posedge core_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      b = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    logic r;
    r = 1'b0;
    s_axi_araddr <= {24'h00_0000, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!r) begin
      @(posedge core_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      r = s_axi_rvalid;
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
    end
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic final_report();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    #100000;
    num_errors++;
    final_report();
  end
  initial begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    chk(feedback_denominator, 64'h0000_0000_0000_0001);
    rd(spcc_pkg::FB_BP_OFF);
    chk(rdat, 64'h0000_0000_0000_0009);
    rd(spcc_pkg::SS_RATE_OFF);
    chk(rdat, spcc_pkg::SS_RATE_RST);
    $display("test reset done");
    wr(spcc_pkg::FREQ_LO_OFF, 32'h89AB_CDEF);
    wr(spcc_pkg::FREQ_HI_OFF, 32'h0000_0012);
    chk(osc_frequency_word, 64'h0000_0012_89AB_CDEF);
    // Spread also needs the oscillator block enabled
    wr(spcc_pkg::LOOP_EN_OFF, 32'h0000_0002);
    wr(spcc_pkg::OSC_CTRL_OFF, 32'h0000_0002);
    chk(ss_active, 1'b1);
    wr(spcc_pkg::OSC_CTRL_OFF, 32'h0000_0001);
    chk(ss_active, 1'b0);
    $display("test mode done");
    // Switch off: the pin must be ignored even when high
    wr(spcc_pkg::PLL_CTL3_OFF, 32'h0000_0051);
    gp_pin <= 4'h1;
    repeat (6) @(posedge core_clk);
    chk(ref_select, 3'h1);
    wr(spcc_pkg::PLL_CTL3_OFF, 32'h0000_0151);
    chk(ref_select, 3'h5);
    gp_pin <= 4'h0;
    repeat (6) @(posedge core_clk);
    chk(ref_select, 3'h1);
    $display("test mux done");
    wr(spcc_pkg::FB_BP_OFF, 32'h0000_0009);
    wr(spcc_pkg::LOOP_EN_OFF, 32'h0000_0000);
    chk(loop_enable_out, 1'b0);
    wr(spcc_pkg::LOOP_EN_OFF, 32'h0000_0001);
    chk(loop_enable_out, 1'b1);
    $display("test loop done");
    wr(spcc_pkg::IN_CTL_OFF, 32'h0000_0063);
    chk(in_divide_log2, 64'h0000_0000_0000_000B);
    chk(in_invert, 64'h0000_0000_0000_0002);
    wr(spcc_pkg::OUT_CTL_OFF, 32'h0000_003D);
    chk(out_ctl[0], 64'h0000_0000_0000_0074);
    wr(spcc_pkg::OUT_EN_OFF, 32'h0000_0001);
    chk(out_ctl[0], 64'h0000_0000_0000_00F4);
    $display("test io done");
    steps = 0;
    wr(spcc_pkg::PLL_CTL4_OFF, 32'h0000_0100);
    wr(spcc_pkg::PLL_CTL4_OFF, 32'h0000_0000);
    chk(64'(steps), 64'h0000_0000_0000_0002);
    wr(spcc_pkg::PLL_CTL4_OFF, 32'h0000_0001);
    gp_pin <= 4'h1;
    repeat (8) @(posedge core_clk);
    gp_pin <= 4'h0;
    repeat (8) @(posedge core_clk);
    chk(64'(steps), 64'h0000_0000_0000_0004);
    wr(spcc_pkg::PLL_CTL4_OFF, 32'h0000_0201);
    chk(64'(advs), 64'h0000_0000_0000_0001);
    $display("test phase done");
    loop_locked <= 1'b1;
    repeat (6) @(posedge core_clk);
    rd(spcc_pkg::STATUS_OFF);
    chk(rdat[1:0], 2'b01);
    rd(8'h40);
    chk(rrsp, 2'b10);
    $display("test status done");
    final_report();
  end
endmodule
